//--- rtl/mfti_top.sv
// mfti_top: fill thresholds, nearly-full / nearly-empty flags and the
// gated, sticky FIFO error status with its shared interrupt.
// assumes fill counts and error pulses come from fabric logic on clk.
`timescale 1ns/10ps

module mfti_top
   import mfti_pkg::*;
#(
   parameter int CNT_W = 5
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   // avalon-mm slave
   input  wire logic [MFTI_ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [MFTI_DATA_W-1:0] avs_writedata,
   input  wire logic [MFTI_BE_W-1:0]   avs_byteenable,
   output logic      [MFTI_DATA_W-1:0] avs_readdata,
   output logic                        avs_waitrequest,
   // write data fifo level
   input  wire logic [CNT_W-1:0]       wr_data_free_slots,
   output logic                        write_data_nearly_full,
   // read data fifo level
   input  wire logic [CNT_W-1:0]       rd_data_fill_slots,
   output logic                        read_data_nearly_empty,
   // fifo error events, one-cycle pulses
   input  wire logic                   rd_data_underrun,
   input  wire logic                   rd_instr_underrun,
   input  wire logic                   wr_data_underrun,
   input  wire logic                   wr_instr_underrun,
   input  wire logic                   rd_data_overrun,
   input  wire logic                   rd_instr_overrun,
   input  wire logic                   wr_data_overrun,
   input  wire logic                   wr_instr_overrun,
   // shared interrupt
   output logic                        memctl_fifo_error_irq
);

   ////////////////////////////////////////////////////////////////////
   // parameter check: a count narrower than the limit cannot compare

   if (CNT_W < MFTI_LIMIT_W || CNT_W > 16) begin : g_bad_cnt_w
      $error("mfti_top: CNT_W must be 4 to 16");
   end

   ////////////////////////////////////////////////////////////////////
   // helpers

   // level at or below limit, limit widened to the count width
   function automatic logic at_or_below(input logic [CNT_W-1:0]        level,
                                        input logic [MFTI_LIMIT_W-1:0] limit);
      logic [CNT_W-1:0] wide;
      // size cast rather than a replication that is empty at CNT_W of 4
      wide = CNT_W'(limit);
      return (level <= wide);
   endfunction

   // word-aligned hit on a register index
   function automatic logic addr_hit(input logic [MFTI_ADDR_W-1:0] addr,
                                     input logic [19:0]            idx);
      return (addr == {idx, 2'b00});
   endfunction

   ////////////////////////////////////////////////////////////////////
   // declarations

   mfti_bus_e                 bus_state_reg;
   mfti_bus_e                 bus_state_next;
   logic                      waitreq_reg;
   logic                      waitreq_next;
   logic [MFTI_DATA_W-1:0]    rdata_reg;
   logic [MFTI_DATA_W-1:0]    rdata_next;

   logic [MFTI_REG_W-1:0]     thresh_reg;
   logic [MFTI_REG_W-1:0]     thresh_next;
   logic [MFTI_REG_W-1:0]     enable_reg;
   logic [MFTI_REG_W-1:0]     enable_next;
   logic [MFTI_REG_W-1:0]     status_reg;
   logic [MFTI_REG_W-1:0]     status_next;

   logic                      nfull_reg;
   logic                      nfull_next;
   logic                      nempty_reg;
   logic                      nempty_next;
   logic                      irq_reg;
   logic                      irq_next;

   logic                      req;
   logic                      wr_commit;
   logic [MFTI_REG_W-1:0]     events;
   logic [MFTI_REG_W-1:0]     clear_mask;
   logic [MFTI_LIMIT_W-1:0]   wr_limit;
   logic [MFTI_LIMIT_W-1:0]   rd_limit;

   ////////////////////////////////////////////////////////////////////
   // event collection in status bit order

   always_comb begin
      events                   = '0;
      events[MFTI_RD_DATA_UR]  = rd_data_underrun;
      events[MFTI_RD_INSTR_UR] = rd_instr_underrun;
      events[MFTI_WR_DATA_UR]  = wr_data_underrun;
      events[MFTI_WR_INSTR_UR] = wr_instr_underrun;
      events[MFTI_RD_DATA_OV]  = rd_data_overrun;
      events[MFTI_RD_INSTR_OV] = rd_instr_overrun;
      events[MFTI_WR_DATA_OV]  = wr_data_overrun;
      events[MFTI_WR_INSTR_OV] = wr_instr_overrun;
   end

   ////////////////////////////////////////////////////////////////////
   // avalon handshake: one wait cycle, then a single ack cycle

   assign req       = avs_read | avs_write;
   // write lands only on the edge where waitrequest is sampled low
   assign wr_commit = avs_write && (bus_state_reg == MFTI_BUS_ACK)
                      && avs_byteenable[0];

   always_comb begin
      bus_state_next = bus_state_reg;
      waitreq_next   = 1'b1;
      rdata_next     = rdata_reg;
      case (bus_state_reg)
         MFTI_BUS_IDLE: begin
            if (req) begin
               bus_state_next = MFTI_BUS_ACK;
               waitreq_next   = 1'b0;
               // unmapped and write-only addresses read as zero
               rdata_next     = '0;
               if (avs_read) begin
                  if (addr_hit(avs_address, MFTI_IDX_THRESH)) begin
                     rdata_next[MFTI_REG_W-1:0] = thresh_reg;
                  end else if (addr_hit(avs_address, MFTI_IDX_ENABLE)) begin
                     rdata_next[MFTI_REG_W-1:0] = enable_reg;
                  end else if (addr_hit(avs_address, MFTI_IDX_STATUS)) begin
                     rdata_next[MFTI_REG_W-1:0] = status_reg;
                  end
               end
            end
         end
         MFTI_BUS_ACK: begin
            bus_state_next = MFTI_BUS_IDLE;
         end
         default: begin
            bus_state_next = MFTI_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_state_reg <= MFTI_BUS_IDLE;
         waitreq_reg   <= 1'b1;
         rdata_reg     <= MFTI_RDATA_RST;
      end else begin
         bus_state_reg <= bus_state_next;
         waitreq_reg   <= waitreq_next;
         rdata_reg     <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers

   always_comb begin
      thresh_next = thresh_reg;
      enable_next = enable_reg;
      clear_mask  = '0;
      if (wr_commit) begin
         if (addr_hit(avs_address, MFTI_IDX_THRESH)) begin
            thresh_next = avs_writedata[MFTI_REG_W-1:0];
         end
         if (addr_hit(avs_address, MFTI_IDX_ENABLE)) begin
            enable_next = avs_writedata[MFTI_REG_W-1:0];
         end
         if (addr_hit(avs_address, MFTI_IDX_CLEAR)) begin
            clear_mask = avs_writedata[MFTI_REG_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         thresh_reg <= MFTI_THRESH_RST;
         enable_reg <= MFTI_ENABLE_RST;
      end else begin
         thresh_reg <= thresh_next;
         enable_reg <= enable_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // level flags; registered, so they trail the counts by one cycle

   assign wr_limit = thresh_reg[MFTI_WR_LIMIT_LSB +: MFTI_LIMIT_W];
   assign rd_limit = thresh_reg[MFTI_RD_LIMIT_LSB +: MFTI_LIMIT_W];

   always_comb begin
      nfull_next  = at_or_below(wr_data_free_slots, wr_limit);
      nempty_next = at_or_below(rd_data_fill_slots, rd_limit);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nfull_reg  <= 1'b0;
         nempty_reg <= 1'b0;
      end else begin
         nfull_reg  <= nfull_next;
         nempty_reg <= nempty_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sticky status; a masked event is dropped, not held back

   always_comb begin
      // set beats clear so an event in the clear cycle survives
      status_next = (status_reg & ~clear_mask)
                  | (events & enable_reg);
      // one shared line; flags cleared by software drop it
      irq_next    = |(status_next & enable_next);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= MFTI_STATUS_RST;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg    <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from flops

   assign avs_readdata           = rdata_reg;
   assign avs_waitrequest        = waitreq_reg;
   assign write_data_nearly_full = nfull_reg;
   assign read_data_nearly_empty = nempty_reg;
   assign memctl_fifo_error_irq  = irq_reg;

endmodule // mfti_top

//--- rtl/mfti_pkg.sv
// mfti_pkg: register map, field layout and reset values of the
// memory-controller FIFO threshold and error-interrupt block.
// assumes a 32-bit Avalon-MM slave port with byte addressing.
package mfti_pkg;

   ////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [19:0] MFTI_IDX_THRESH   = 20'h30B00;
   localparam logic [19:0] MFTI_IDX_ENABLE   = 20'h30B01;
   localparam logic [19:0] MFTI_IDX_STATUS   = 20'h30B08;
   localparam logic [19:0] MFTI_IDX_CLEAR    = 20'h30B10;

   localparam int          MFTI_ADDR_W       = 22;
   localparam int          MFTI_DATA_W       = 32;
   localparam int          MFTI_BE_W         = 4;
   localparam int          MFTI_REG_W        = 8;
   localparam int          MFTI_LIMIT_W      = 4;

   ////////////////////////////////////////////////////////////////////
   // threshold register fields
   localparam int          MFTI_WR_LIMIT_LSB = 0;
   localparam int          MFTI_RD_LIMIT_LSB = 4;

   ////////////////////////////////////////////////////////////////////
   // status, enable and clear share this bit layout
   localparam int          MFTI_RD_DATA_UR   = 0;
   localparam int          MFTI_RD_INSTR_UR  = 1;
   localparam int          MFTI_WR_DATA_UR   = 2;
   localparam int          MFTI_WR_INSTR_UR  = 3;
   localparam int          MFTI_RD_DATA_OV   = 4;
   localparam int          MFTI_RD_INSTR_OV  = 5;
   localparam int          MFTI_WR_DATA_OV   = 6;
   localparam int          MFTI_WR_INSTR_OV  = 7;

   ////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0]  MFTI_THRESH_RST   = 8'h00;
   localparam logic [7:0]  MFTI_ENABLE_RST   = 8'h00;
   localparam logic [7:0]  MFTI_STATUS_RST   = 8'h00;
   localparam logic [31:0] MFTI_RDATA_RST    = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////
   // bus handshake states
   typedef enum logic [0:0] {
      MFTI_BUS_IDLE = 1'b0,
      MFTI_BUS_ACK  = 1'b1
   } mfti_bus_e;

endpackage : mfti_pkg

//--- dv/mfti_props.sv
// mfti_props: port checks of the fifo threshold and error irq block.
// assumes the byte-addressed avalon slave of mfti_top; bound below.
`timescale 1ns/10ps
module mfti_props
   import mfti_pkg::*;
#(parameter int CNT_W = 5) (
   // clock, reset
   input wire logic                   clk,
   input wire logic                   rst_b,
   // avalon
   input wire logic [MFTI_ADDR_W-1:0] avs_address,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [MFTI_DATA_W-1:0] avs_writedata,
   input wire logic [MFTI_BE_W-1:0]   avs_byteenable,
   input wire logic [MFTI_DATA_W-1:0] avs_readdata,
   input wire logic                   avs_waitrequest,
   // levels, events, irq
   input wire logic [CNT_W-1:0]       wr_data_free_slots,
   input wire logic [CNT_W-1:0]       rd_data_fill_slots,
   input wire logic                   write_data_nearly_full,
   input wire logic                   read_data_nearly_empty,
   input wire logic                   rd_data_underrun,
   input wire logic                   rd_instr_underrun,
   input wire logic                   wr_data_underrun,
   input wire logic                   wr_instr_underrun,
   input wire logic                   rd_data_overrun,
   input wire logic                   rd_instr_overrun,
   input wire logic                   wr_data_overrun,
   input wire logic                   wr_instr_overrun,
   input wire logic                   memctl_fifo_error_irq
);
   ////////////////////////////////////////////////////////////////////
   // mirror of the two config registers, from committed writes
   logic [7:0] thr_reg;
   logic [7:0] en_reg;
   wire logic [7:0] ev = {wr_instr_overrun, wr_data_overrun, rd_instr_overrun,
      rd_data_overrun, wr_instr_underrun, wr_data_underrun, rd_instr_underrun,
      rd_data_underrun};
   wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   wire logic rd_ok = avs_read && !avs_waitrequest;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         thr_reg <= 8'h00;
         en_reg  <= 8'h00;
      end else if (wr_ok) begin
         if (avs_address == {MFTI_IDX_THRESH, 2'b00}) thr_reg <= avs_writedata[7:0];
         if (avs_address == {MFTI_IDX_ENABLE, 2'b00}) en_reg <= avs_writedata[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ack; !avs_waitrequest; endsequence
   a_wait_one: assert property (s_req |=> s_ack)
      else $error("request not answered after one wait cycle");
   a_ack_single: assert property (s_ack |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_full_cmp: assert property ($past(rst_b) |-> write_data_nearly_full ==
      ($past(wr_data_free_slots) <= ($past(thr_reg) & 8'h0F))) else $error("nearly full wrong");
   a_empty_cmp: assert property ($past(rst_b) |-> read_data_nearly_empty ==
      ($past(rd_data_fill_slots) <= ($past(thr_reg) >> 4))) else $error("nearly empty wrong");
   a_irq_set: assert property (|(ev & en_reg) |=> memctl_fifo_error_irq)
      else $error("enabled event did not raise irq");
   a_irq_masked: assert property (en_reg == 8'h00 |=> !memctl_fifo_error_irq)
      else $error("irq with all enables clear");
   a_thr_read: assert property (rd_ok && avs_address == {MFTI_IDX_THRESH, 2'b00}
      |-> avs_readdata == {24'h000000, thr_reg}) else $error("threshold readback wrong");
   a_clr_read: assert property (rd_ok && avs_address == {MFTI_IDX_CLEAR, 2'b00}
      |-> avs_readdata == 32'h00000000) else $error("clear register not zero");
endmodule // mfti_props
bind mfti_top mfti_props #(.CNT_W(CNT_W)) i_props (.*);

//--- dv/mfti_fabric_model.sv
// mfti_fabric_model: fabric side; fifo fill counts and error pulses.
// assumes the bench calls its tasks; outputs move just after clk edges.
`timescale 1ns/10ps
module mfti_fabric_model #(parameter int CNT_W = 5) (
   // clock
   input wire logic         clk,
   // levels and pulses
   output logic [CNT_W-1:0] free_slots,
   output logic [CNT_W-1:0] fill_slots,
   output logic [7:0]       err_pulse
);
   initial begin
      free_slots = '0;
      fill_slots = '0;
      err_pulse  = 8'h00;
   end
   task automatic set_levels(input logic [CNT_W-1:0] fr, input logic [CNT_W-1:0] fl);
      @(posedge clk);
      free_slots <= fr;
      fill_slots <= fl;
   endtask
   // one cycle only: a held level would set the flag every cycle
   task automatic pulse(input logic [7:0] m);
      @(posedge clk);
      err_pulse <= m;
      @(posedge clk);
      err_pulse <= 8'h00;
   endtask
endmodule // mfti_fabric_model

//--- dv/mfti_top_tb.sv
// mfti_top_tb: register, threshold and irq scenarios of mfti_top.
// assumes mfti_props is bound and the fabric model drives the fifo side.
`timescale 1ns/10ps
module mfti_top_tb import mfti_pkg::*;;
   logic        clk = 1'b0, rst_b = 1'b0, rdq = 1'b0, wrq = 1'b0;
   logic [21:0] adr = 22'h000000;
   logic [31:0] wdat = 32'h00000000;
   logic [3:0]  be = 4'hF;
   logic [31:0] rdat, rd;
   logic        wait_r, nfull, nempty, irq;
   logic [4:0]  free_s, fill_s;
   logic [7:0]  ev, m;
   int          error_cnt = 0, samples_checked = 0;
   always #5 clk = ~clk;
   mfti_fabric_model #(.CNT_W(5)) i_fab (.clk(clk), .free_slots(free_s),
      .fill_slots(fill_s), .err_pulse(ev));
   mfti_top #(.CNT_W(5)) i_dut (.clk(clk), .rst_b(rst_b), .avs_address(adr),
      .avs_read(rdq), .avs_write(wrq), .avs_writedata(wdat), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wait_r), .wr_data_free_slots(free_s),
      .write_data_nearly_full(nfull), .rd_data_fill_slots(fill_s),
      .read_data_nearly_empty(nempty), .rd_data_underrun(ev[0]),
      .rd_instr_underrun(ev[1]), .wr_data_underrun(ev[2]), .wr_instr_underrun(ev[3]),
      .rd_data_overrun(ev[4]), .rd_instr_overrun(ev[5]), .wr_data_overrun(ev[6]),
      .wr_instr_overrun(ev[7]), .memctl_fifo_error_irq(irq));
   ////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [19:0] idx, input logic [7:0] wd);
      int k;
      @(posedge clk);
      adr  <= {idx, 2'b00};
      wrq  <= wr;
      rdq  <= !wr;
      wdat <= {24'h000000, wd};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wait_r !== 1'b0 && k < 20);
      rd = rdat;
      wrq <= 1'b0;
      rdq <= 1'b0;
      if (wait_r !== 1'b0) begin
         error_cnt++;
         end_sim();
      end
   endtask
   task automatic rdchk(input logic [19:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h000000, exp});
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdchk(MFTI_IDX_THRESH, 8'h00);
      rdchk(MFTI_IDX_ENABLE, 8'h00);
      rdchk(MFTI_IDX_STATUS, 8'h00);
      rdchk(20'h30B02, 8'h00);
      rdchk(MFTI_IDX_CLEAR, 8'h00);
      chk(irq, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_thresh();
      bus(1'b1, MFTI_IDX_THRESH, 8'hA4);
      rdchk(MFTI_IDX_THRESH, 8'hA4);
      // byte lane 0 off: the write must leave the limits alone
      be <= 4'hE;
      bus(1'b1, MFTI_IDX_THRESH, 8'h5F);
      be <= 4'hF;
      rdchk(MFTI_IDX_THRESH, 8'hA4);
      i_fab.set_levels(5'h05, 5'h0B);
      repeat (2) @(posedge clk);
      chk(nfull, 1'b0);
      chk(nempty, 1'b0);
      i_fab.set_levels(5'h04, 5'h0A);
      repeat (2) @(posedge clk);
      chk(nfull, 1'b1);
      chk(nempty, 1'b1);
      $display("test thresholds done");
   endtask
   task automatic t_events();
      for (int n = 0; n < 8; n++) begin
         m = 8'h01 << n;
         bus(1'b1, MFTI_IDX_ENABLE, 8'h00);
         i_fab.pulse(m);
         rdchk(MFTI_IDX_STATUS, 8'h00);
         chk(irq, 1'b0);
         bus(1'b1, MFTI_IDX_ENABLE, m);
         i_fab.pulse(m);
         @(posedge clk);
         chk(irq, 1'b1);
         rdchk(MFTI_IDX_STATUS, m);
         bus(1'b1, MFTI_IDX_ENABLE, ~m);
         repeat (2) @(posedge clk);
         chk(irq, 1'b0);
         rdchk(MFTI_IDX_STATUS, m);
         bus(1'b1, MFTI_IDX_CLEAR, m);
         rdchk(MFTI_IDX_STATUS, 8'h00);
      end
      $display("test events done");
   endtask
   // event lands on the very edge that commits its clear: the set must win
   task automatic t_set_wins();
      bus(1'b1, MFTI_IDX_ENABLE, 8'h01);
      fork
         bus(1'b1, MFTI_IDX_CLEAR, 8'h01);
         begin
            @(posedge clk);
            i_fab.pulse(8'h01);
         end
      join
      rdchk(MFTI_IDX_STATUS, 8'h01);
      chk(irq, 1'b1);
      bus(1'b1, MFTI_IDX_CLEAR, 8'h01);
      rdchk(MFTI_IDX_STATUS, 8'h00);
      $display("test set wins done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_thresh();
      t_events();
      t_set_wins();
      end_sim();
   end
endmodule // mfti_top_tb
